// ==== logic/gmx_pkg.sv ====
// Constants shared by the pin-function multiplexer and its input conditioner
package gmx_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    localparam int          NUM_GP          = 6;
    localparam int          NUM_PINS        = 8;
    localparam int          SEL_W           = 4;

    // Register offsets
    localparam logic [7:0]  ADDR_CLK_SRC    = 8'h08;
    localparam logic [7:0]  ADDR_PORT_SEL   = 8'h09;
    localparam logic [7:0]  ADDR_PIN_FN     = 8'h0a;
    localparam logic [7:0]  ADDR_STATUS     = 8'h12;
    localparam logic [7:0]  ADDR_PIN12      = 8'h13;
    localparam logic [7:0]  ADDR_PIN34      = 8'h14;
    localparam logic [7:0]  ADDR_PIN56      = 8'h15;
    localparam logic [7:0]  ADDR_INPUT_CTRL = 8'h16;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h17;

    // Field positions
    localparam int          MASTER_CLOCK_SOURCE_SEL_BIT    = 15;
    localparam int          PORT_SEL_BIT    = 13;
    localparam int          PIN1_FN_BIT     = 15;
    localparam int          PIN6_FN_BIT     = 14;
    localparam int          TRIS_BIT        = 13;
    // Per-pin byte: odd pins in the low byte, even pins in the high byte
    localparam int          FLD_DEB         = 7;
    localparam int          FLD_IRQ_ENA     = 6;
    localparam int          FLD_PU          = 5;
    localparam int          FLD_PD          = 4;
    localparam int          FLD_SEL_LSB     = 0;
    // Input control: polarity per pin, then detect-pin enables and debounce
    localparam int          IC_POL_LSB      = 0;
    localparam int          IC_DET_ENA_LSB  = 8;
    localparam int          IC_DET_DEB_LSB  = 10;
    localparam int          IC_TIMEOUT_CLOCK_BIT    = 12;

    // Reset values
    localparam logic [15:0] RST_CLK_SRC     = 16'h0000;
    localparam logic [15:0] RST_PORT_SEL    = 16'h0000;
    localparam logic [15:0] RST_PIN_FN      = 16'h0000;
    localparam logic [15:0] RST_PIN12       = 16'h1000;
    localparam logic [15:0] RST_PIN34       = 16'h1010;
    localparam logic [15:0] RST_PIN56       = 16'h1010;
    localparam logic [15:0] RST_INPUT_CTRL  = 16'h0000;
    localparam logic [15:0] RST_IRQ_MASK    = 16'h0000;

    // Per-pin function codes
    localparam logic [3:0]  FN_INPUT        = 4'h0;
    localparam logic [3:0]  FN_CLK_OUT      = 4'h1;
    localparam logic [3:0]  FN_LOGIC0       = 4'h2;
    localparam logic [3:0]  FN_LOGIC1       = 4'h3;
    localparam logic [3:0]  FN_TEMP_OK      = 4'h4;
    localparam logic [3:0]  FN_FLL_LOCK     = 4'h5;
    localparam logic [3:0]  FN_IRQ          = 4'h6;

    // Timing
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          TIMEOUT_PERIOD_NS = 10000;
    localparam int          TIMEOUT_CYCLES    = TIMEOUT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          DEB_TICKS         = 4;
endpackage : gmx_pkg

// ==== logic/gmx_pin_input.sv ====
// Input conditioner: synchroniser, polarity and optional debounce for one pin
module gmx_pin_input
    import gmx_pkg::*;
#(
    parameter int DEB_COUNT = DEB_TICKS
)(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic pin_level,
    input  wire logic invert,
    input  wire logic debounce_ena,
    input  wire logic tick,
    output logic      level_out
);
    logic       sync1_q;
    logic       sync2_q;
    logic       level_q;
    logic       level_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       pol;

    always_comb
    begin
        pol     = sync2_q ^ invert;
        level_d = level_q;
        cnt_d   = cnt_q;
        if (!debounce_ena)
        begin
            level_d = pol;
            cnt_d   = 8'h00;
        end
        else if (pol == level_q)
        begin
            cnt_d = 8'h00;
        end
        else if (tick)
        begin
            // Without timeout ticks a debounced level never moves
            if (cnt_q >= 8'(DEB_COUNT - 1))
            begin
                level_d = pol;
                cnt_d   = 8'h00;
            end
            else
            begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            level_q <= 1'b0;
            cnt_q   <= 8'h00;
        end
        else
        begin
            sync1_q <= pin_level; // RL15
            sync2_q <= sync1_q;
            level_q <= level_d;
            cnt_q   <= cnt_d;
        end
    end

    assign level_out = level_q;
endmodule : gmx_pin_input

// ==== logic/gmx_pin_mux.sv ====
// Pin-function multiplexer for six general pins and two detect inputs
// Operation
// RL1: Master clock comes from dedicated pin, or pin two when source bit set.
// RL2: Port select routes pins three to five to second audio interface.
// RL3: Pin one carries ADC frame clock, or becomes general with internal tie.
// RL4: Pin six is general, or drives inverted ADC frame clock.
// RL5: Tristate-all floats every pin, overriding port, clock and pin settings.
// RL6: Priority is pulls, tristate, pin configuration, then function code.
// RL7: Function code acts only when the pin is left in general use.
// RL8: Reset enables pull-down on pins two to six, none on pin one.
// RL9: Only pins one to six offer pulls and outputs; seven, eight detect only.
// RL10: Pins one to six can drive constant high or constant low.
// RL11: Input pins feed interrupt through enable, optional debounce and polarity.
// RL12: Pin event status bits stay latched once set.
// RL13: Writing one to a status bit clears it.
// RL14: Software enables the timeout clock when debounce is wanted.
// RL15: Pin inputs are synchronised before polarity, debounce and latching.
module gmx_pin_mux
    import gmx_pkg::*;
#(
    parameter int TICK_CYCLES = TIMEOUT_CYCLES,
    parameter int DEB_COUNT   = DEB_TICKS
)(
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic      [DATA_W-1:0]   reg_rdata,
    input  wire logic [NUM_GP-1:0]   pin_in,
    output logic      [NUM_GP-1:0]   pin_out,
    output logic      [NUM_GP-1:0]   pin_oe,
    output logic      [NUM_GP-1:0]   pin_pull_up_enable,
    output logic      [NUM_GP-1:0]   pin_pull_down_enable,
    input  wire logic                detect_input_seven,
    input  wire logic                detect_input_eight,
    input  wire logic                master_clock_pin,
    output logic                     master_clock,
    input  wire logic                adc_frame_clock_core,
    input  wire logic                dac_frame_clock,
    output logic                     adc_frame_clock,
    output logic                     audio_port_select,
    output logic                     alternate_bit_clock,
    output logic                     alternate_dac_frame_clock,
    output logic                     alternate_dac_data,
    input  wire logic                clock_out_src,
    input  wire logic                temperature_ok,
    input  wire logic                fll_locked,
    output logic                     codec_irq
);
    logic [15:0]         clk_src_q,  clk_src_d;
    logic [15:0]         port_sel_q, port_sel_d;
    logic [15:0]         pin_fn_q,   pin_fn_d;
    logic [15:0]         pin_cfg_q [3];
    logic [15:0]         pin_cfg_d [3];
    logic [15:0]         in_ctrl_q,  in_ctrl_d;
    logic [15:0]         irq_mask_q, irq_mask_d;
    logic [7:0]          status_q,   status_d;
    logic [DATA_W-1:0]   rdata_q,    rdata_d;
    logic [NUM_GP-1:0]   pin_out_q,  pin_out_d;
    logic [NUM_GP-1:0]   pin_oe_q,   pin_oe_d;
    logic                irq_q,      irq_d;
    logic [15:0]         tick_cnt_q, tick_cnt_d;
    logic                tick;
    logic [NUM_PINS-1:0] level_prev_q;
    logic [NUM_PINS-1:0] raw_level;
    logic [NUM_PINS-1:0] clean_level;
    logic [NUM_PINS-1:0] deb_ena;
    logic [NUM_PINS-1:0] evt_ena;
    logic [NUM_PINS-1:0] input_mode;
    logic [NUM_PINS-1:0] event_hit;
    logic                tris;
    logic                mclk_alt;
    logic                aif2;
    logic                pin1_gp;
    logic                pin6_alt;
    logic                adc_eff;
    logic [7:0]          pcfg [NUM_GP];
    logic [NUM_GP-1:0]   claimed;

    // Configuration settings, each overridden by tristate-all
    always_comb
    begin
        tris     = pin_fn_q[TRIS_BIT];
        mclk_alt = clk_src_q[MASTER_CLOCK_SOURCE_SEL_BIT] & ~tris;   // RL5
        aif2     = port_sel_q[PORT_SEL_BIT] & ~tris;  // RL5
        pin1_gp  = pin_fn_q[PIN1_FN_BIT] & ~tris;     // RL5
        pin6_alt = pin_fn_q[PIN6_FN_BIT] & ~tris;     // RL5
        // Internal tie when pin one is given away to general use
        adc_eff  = pin1_gp ? dac_frame_clock : adc_frame_clock_core; // RL3
        for (int i = 0; i < NUM_GP; i++)
        begin
            pcfg[i] = pin_cfg_q[i / 2][8 * (i % 2) +: 8];
        end
        claimed    = '0;
        claimed[0] = ~pin1_gp & ~tris;  // RL3
        claimed[1] = mclk_alt;          // RL1
        claimed[2] = aif2;              // RL2
        claimed[3] = aif2;              // RL2
        claimed[4] = aif2;              // RL2
        claimed[5] = pin6_alt;          // RL4
    end

    assign master_clock              = mclk_alt ? pin_in[1] : master_clock_pin; // RL1
    assign adc_frame_clock           = adc_eff;
    assign audio_port_select         = aif2;                                    // RL2
    assign alternate_bit_clock       = aif2 & pin_in[2];                        // RL2
    assign alternate_dac_frame_clock = aif2 & pin_in[3];                        // RL2
    assign alternate_dac_data        = aif2 & pin_in[4];                        // RL2

    // Pin drive resolution in precedence order
    always_comb
    begin
        for (int i = 0; i < NUM_GP; i++)
        begin
            pin_out_d[i]            = 1'b0;
            pin_oe_d[i]             = 1'b0;
            pin_pull_up_enable[i]   = pcfg[i][FLD_PU];  // RL9
            pin_pull_down_enable[i] = pcfg[i][FLD_PD];  // RL9
            input_mode[i]           = 1'b0;
            if (pcfg[i][FLD_PU] | pcfg[i][FLD_PD])
            begin
                // A pulled pin is never driven, and is an input unless claimed; the driver would fight the resistor
                input_mode[i] = ~claimed[i];            // RL6
            end
            else if (tris)
            begin
                pin_oe_d[i]   = 1'b0;                   // RL5 RL6
                input_mode[i] = (pcfg[i][FLD_SEL_LSB +: SEL_W] == FN_INPUT);
            end
            else if (claimed[i])
            begin
                if (i == 0)
                begin
                    pin_out_d[i] = adc_frame_clock_core; // RL3
                    pin_oe_d[i]  = 1'b1;
                end
                else if (i == 5)
                begin
                    pin_out_d[i] = ~adc_eff;             // RL4
                    pin_oe_d[i]  = 1'b1;
                end
            end
            else
            begin
                pin_oe_d[i] = 1'b1;                      // RL7
                unique case (pcfg[i][FLD_SEL_LSB +: SEL_W])
                    FN_INPUT:
                    begin
                        pin_oe_d[i]   = 1'b0;
                        input_mode[i] = 1'b1;
                    end
                    FN_CLK_OUT:  pin_out_d[i] = clock_out_src;
                    FN_LOGIC0:   pin_out_d[i] = 1'b0;    // RL10
                    FN_LOGIC1:   pin_out_d[i] = 1'b1;    // RL10
                    FN_TEMP_OK:  pin_out_d[i] = temperature_ok;
                    FN_FLL_LOCK: pin_out_d[i] = fll_locked;
                    FN_IRQ:      pin_out_d[i] = irq_q;
                    default:     pin_oe_d[i]  = 1'b0;
                endcase
            end
        end
        input_mode[6] = 1'b1; // RL9
        input_mode[7] = 1'b1; // RL9
    end

    // Timeout clock as a one-cycle enable; debounce stalls while it is off
    always_comb
    begin
        tick       = 1'b0;
        tick_cnt_d = tick_cnt_q;
        if (!in_ctrl_q[IC_TIMEOUT_CLOCK_BIT])
        begin
            tick_cnt_d = 16'h0000; // RL14
        end
        else if (tick_cnt_q >= 16'(TICK_CYCLES - 1))
        begin
            tick       = 1'b1;
            tick_cnt_d = 16'h0000;
        end
        else
        begin
            tick_cnt_d = tick_cnt_q + 16'h0001;
        end
    end

    always_comb
    begin
        raw_level = {detect_input_eight, detect_input_seven, pin_in};
        for (int i = 0; i < NUM_GP; i++)
        begin
            deb_ena[i] = pcfg[i][FLD_DEB];
            evt_ena[i] = pcfg[i][FLD_IRQ_ENA];
        end
        deb_ena[7:6] = in_ctrl_q[IC_DET_DEB_LSB +: 2];
        evt_ena[7:6] = in_ctrl_q[IC_DET_ENA_LSB +: 2];
    end

    for (genvar g = 0; g < NUM_PINS; g++)
    begin : g_input
        gmx_pin_input #(
            .DEB_COUNT    (DEB_COUNT)
        ) u_input (
            .clock        (clock),
            .arst_n       (arst_n),
            .pin_level    (raw_level[g]),
            .invert       (in_ctrl_q[IC_POL_LSB + g]),
            .debounce_ena (deb_ena[g]),
            .tick         (tick),
            .level_out    (clean_level[g])
        ); // RL11
    end

    // Register writes, status latching and read data
    always_comb
    begin
        clk_src_d  = clk_src_q;
        port_sel_d = port_sel_q;
        pin_fn_d   = pin_fn_q;
        pin_cfg_d  = pin_cfg_q;
        in_ctrl_d  = in_ctrl_q;
        irq_mask_d = irq_mask_q;
        status_d   = status_q;
        rdata_d    = '0;
        event_hit  = clean_level & ~level_prev_q & evt_ena & input_mode; // RL11
        if (reg_write)
        begin
            unique case (reg_addr)
                ADDR_CLK_SRC:    clk_src_d    = reg_wdata;
                ADDR_PORT_SEL:   port_sel_d   = reg_wdata;
                ADDR_PIN_FN:     pin_fn_d     = reg_wdata;
                ADDR_PIN12:      pin_cfg_d[0] = reg_wdata;
                ADDR_PIN34:      pin_cfg_d[1] = reg_wdata;
                ADDR_PIN56:      pin_cfg_d[2] = reg_wdata;
                ADDR_INPUT_CTRL: in_ctrl_d    = reg_wdata;
                ADDR_IRQ_MASK:   irq_mask_d   = reg_wdata;
                ADDR_STATUS:     status_d     = status_q & ~reg_wdata[7:0]; // RL13
                default:         ;
            endcase
        end
        // A new event beats a clear in the same cycle
        status_d = status_d | event_hit; // RL12
        irq_d    = |(status_q & irq_mask_q[7:0]);
        if (reg_read)
        begin
            unique case (reg_addr)
                ADDR_CLK_SRC:    rdata_d = clk_src_q;
                ADDR_PORT_SEL:   rdata_d = port_sel_q;
                ADDR_PIN_FN:     rdata_d = pin_fn_q;
                ADDR_PIN12:      rdata_d = pin_cfg_q[0];
                ADDR_PIN34:      rdata_d = pin_cfg_q[1];
                ADDR_PIN56:      rdata_d = pin_cfg_q[2];
                ADDR_INPUT_CTRL: rdata_d = in_ctrl_q;
                ADDR_IRQ_MASK:   rdata_d = irq_mask_q;
                ADDR_STATUS:     rdata_d = {8'h00, status_q};
                default:         rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_src_q    <= RST_CLK_SRC;
            port_sel_q   <= RST_PORT_SEL;
            pin_fn_q     <= RST_PIN_FN;
            pin_cfg_q[0] <= RST_PIN12;  // RL8
            pin_cfg_q[1] <= RST_PIN34;  // RL8
            pin_cfg_q[2] <= RST_PIN56;  // RL8
            in_ctrl_q    <= RST_INPUT_CTRL;
            irq_mask_q   <= RST_IRQ_MASK;
            status_q     <= 8'h00;
            rdata_q      <= '0;
            pin_out_q    <= '0;
            pin_oe_q     <= '0;
            irq_q        <= 1'b0;
            tick_cnt_q   <= 16'h0000;
            level_prev_q <= '0;
        end
        else
        begin
            clk_src_q    <= clk_src_d;
            port_sel_q   <= port_sel_d;
            pin_fn_q     <= pin_fn_d;
            pin_cfg_q    <= pin_cfg_d;
            in_ctrl_q    <= in_ctrl_d;
            irq_mask_q   <= irq_mask_d;
            status_q     <= status_d;
            rdata_q      <= rdata_d;
            pin_out_q    <= pin_out_d;
            pin_oe_q     <= pin_oe_d;
            irq_q        <= irq_d;
            tick_cnt_q   <= tick_cnt_d;
            level_prev_q <= clean_level;
        end
    end

    assign reg_rdata = rdata_q;
    assign pin_out   = pin_out_q;
    assign pin_oe    = pin_oe_q;
    assign codec_irq = irq_q;
endmodule : gmx_pin_mux

// ==== tb/gmx_pin_mux_properties.sv ====
// Port-level assertions for the pin-function multiplexer
module gmx_pin_mux_properties
    import gmx_pkg::*;
(
    input wire logic              clock,
    input wire logic              arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic [NUM_GP-1:0] pin_in,
    input wire logic [NUM_GP-1:0] pin_out,
    input wire logic [NUM_GP-1:0] pin_oe,
    input wire logic [NUM_GP-1:0] pin_pull_up_enable,
    input wire logic [NUM_GP-1:0] pin_pull_down_enable,
    input wire logic              master_clock_pin,
    input wire logic              master_clock,
    input wire logic              adc_frame_clock_core,
    input wire logic              dac_frame_clock,
    input wire logic              adc_frame_clock,
    input wire logic              audio_port_select,
    input wire logic              alternate_bit_clock,
    input wire logic              alternate_dac_frame_clock,
    input wire logic              alternate_dac_data,
    input wire logic              codec_irq
);
    logic mclk_q, port_q, p1_q, p6_q, tris_q;
    wire  clr_w = reg_write && (reg_addr == ADDR_STATUS || reg_addr == ADDR_IRQ_MASK);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Config bits seen through the register port
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
            {mclk_q, port_q, p1_q, p6_q, tris_q} <= '0;
        else if (reg_write)
        begin
            if (reg_addr == ADDR_CLK_SRC) mclk_q <= reg_wdata[MASTER_CLOCK_SOURCE_SEL_BIT];
            if (reg_addr == ADDR_PORT_SEL) port_q <= reg_wdata[PORT_SEL_BIT];
            if (reg_addr == ADDR_PIN_FN) {p1_q, p6_q, tris_q} <= reg_wdata[15:13];
        end
    sequence s_pin1_clock;
        !p1_q && !tris_q;
    endsequence
    sequence s_pin6_clock;
        p6_q && !tris_q;
    endsequence
    chk_mclk_source: assert property (master_clock == (mclk_q && !tris_q ? pin_in[1] : master_clock_pin))
        else $error("clock source wrong");
    chk_port_select: assert property (audio_port_select == (port_q && !tris_q))
        else $error("port select wrong");
    chk_port_pins: assert property (audio_port_select |->
        {alternate_dac_data, alternate_dac_frame_clock, alternate_bit_clock} == pin_in[4:2])
        else $error("port pins wrong");
    chk_adc_tie: assert property (adc_frame_clock == (p1_q && !tris_q ? dac_frame_clock : adc_frame_clock_core))
        else $error("adc frame clock wrong");
    chk_pin1_drive: assert property (s_pin1_clock |=> pin_oe[0] && pin_out[0] == $past(adc_frame_clock_core))
        else $error("pin one clock wrong");
    chk_pin6_inverse: assert property (s_pin6_clock |=> pin_oe[5] && pin_out[5] == !$past(adc_frame_clock))
        else $error("pin six clock wrong");
    chk_tris_float: assert property (tris_q |=> pin_oe == 6'h00)
        else $error("pin driven under tristate");
    chk_pull_float: assert property ((pin_oe & $past(pin_pull_up_enable | pin_pull_down_enable)) == 6'h00)
        else $error("pulled pin driven");
    chk_reset_pulls: assert property ($rose(arst_n) |-> pin_pull_down_enable == 6'h3e && pin_pull_up_enable == 6'h00)
        else $error("pull reset wrong");
    chk_irq_sticky: assert property (codec_irq && !$past(clr_w) |=> codec_irq)
        else $error("interrupt lost");
endmodule : gmx_pin_mux_properties

bind gmx_pin_mux gmx_pin_mux_properties gmx_pin_mux_properties_inst (.*);

// ==== tb/gmx_pin_partner.sv ====
// Buttons and accessories on pins one to six, with the resolved pin level
module gmx_pin_partner
    import gmx_pkg::*;
(
    input  wire logic              clock,
    input  wire logic [NUM_GP-1:0] pin_out,
    input  wire logic [NUM_GP-1:0] pin_oe,
    input  wire logic [NUM_GP-1:0] pin_pull_up_enable,
    input  wire logic [NUM_GP-1:0] pin_pull_down_enable,
    input  wire logic [NUM_GP-1:0] btn_drive,
    input  wire logic [NUM_GP-1:0] btn_level,
    output logic      [NUM_GP-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NUM_GP-1:0] float_q = 6'h15;
    // Undriven line toggles, never stale
    always @(posedge clock)
        float_q <= ~float_q;
    always_comb
        for (int i = 0; i < NUM_GP; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : btn_drive[i] ? btn_level[i] :
                        pin_pull_up_enable[i] ? 1'b1 : pin_pull_down_enable[i] ? 1'b0 : float_q[i];
endmodule : gmx_pin_partner

// ==== tb/tb.sv ====
// Self-checking bench for the pin-function multiplexer
module tb
    import gmx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clock = 0, arst_n = 0, reg_write = 0, reg_read = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    logic [NUM_GP-1:0] pin_in, pin_out, pin_oe, pin_pull_up_enable, pin_pull_down_enable;
    logic [NUM_GP-1:0] btn_drive = '0, btn_level = '0;
    logic              detect_input_seven = 0, detect_input_eight = 0, master_clock_pin = 0, adc_frame_clock_core = 0;
    logic              dac_frame_clock = 0, clock_out_src = 0, temperature_ok = 0, fll_locked = 0;
    logic              master_clock, adc_frame_clock, audio_port_select, codec_irq;
    logic              alternate_bit_clock, alternate_dac_frame_clock, alternate_dac_data;
    int                error_cnt = 0, total_checks = 0;
    logic [7:0]        ra [10] = '{ADDR_CLK_SRC, ADDR_PORT_SEL, ADDR_PIN_FN, ADDR_PIN12, ADDR_PIN34, ADDR_PIN56,
                                   ADDR_INPUT_CTRL, ADDR_IRQ_MASK, ADDR_STATUS, 8'h20};
    logic [15:0]       rv [10] = '{RST_CLK_SRC, RST_PORT_SEL, RST_PIN_FN, RST_PIN12, RST_PIN34, RST_PIN56,
                                   RST_INPUT_CTRL, RST_IRQ_MASK, 16'h0000, 16'h0000};
    logic [3:0]        codes [6] = '{FN_CLK_OUT, FN_LOGIC0, FN_LOGIC1, FN_TEMP_OK, FN_FLL_LOCK, FN_IRQ};

    always #5 clock = ~clock;

    gmx_pin_mux #(.TICK_CYCLES(4), .DEB_COUNT(2)) gmx_pin_mux_inst (.*);
    gmx_pin_partner gmx_pin_partner_inst (.*);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        chk(reg_rdata, e);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic summarize;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    function automatic logic exp_lvl(input logic [3:0] c);
        case (c)
            FN_CLK_OUT:  return clock_out_src;
            FN_LOGIC0, FN_IRQ: return 1'b0;
            FN_TEMP_OK:  return temperature_ok;
            FN_FLL_LOCK: return fll_locked;
            default:     return 1'b1;
        endcase
    endfunction : exp_lvl
    // Bounded wait for the interrupt
    task automatic pin1_event;
        int n;
        @(posedge clock);
        btn_level[0] <= 1'b1;
        cyc(2);
        chk(16'(codec_irq), 16'h0000);
        for (n = 0; n < 10 && codec_irq !== 1'b1; n++) @(negedge clock);
        if (n == 10)
        begin
            error_cnt++;
            summarize();
        end
    endtask : pin1_event

    initial
    begin
        void'($urandom(77));
        cyc(2);
        chk(16'({pin_pull_up_enable, pin_pull_down_enable}), 16'h003e);
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        foreach (ra[i]) rd(ra[i], rv[i]);
        btn_drive <= 6'h1e;
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_CLK_SRC, {m[0], 15'h0000});
            wr(ADDR_PORT_SEL, {2'b00, m[1], 13'h0000});
            repeat (4)
            begin
                @(posedge clock);
                btn_level        <= 6'($urandom);
                master_clock_pin <= 1'($urandom);
                @(negedge clock);
                chk(16'(master_clock), 16'(m[0] ? btn_level[1] : master_clock_pin));
                chk(16'(audio_port_select), 16'(m[1]));
                chk(16'({alternate_dac_data, alternate_dac_frame_clock, alternate_bit_clock}),
                    16'(m[1] ? btn_level[4:2] : 3'b000));
            end
        end
        wr(ADDR_CLK_SRC, 16'h0000);
        wr(ADDR_PORT_SEL, 16'h0000);
        wr(ADDR_PIN56, 16'h0010);
        for (int m = 0; m < 2; m++)
        begin
            wr(ADDR_PIN_FN, {m[0], 15'h4000});
            repeat (4)
            begin
                @(posedge clock);
                adc_frame_clock_core <= 1'($urandom);
                dac_frame_clock      <= 1'($urandom);
                cyc(2);
                chk(16'(adc_frame_clock), 16'(m[0] ? dac_frame_clock : adc_frame_clock_core));
                chk(16'({pin_oe[5], pin_out[5]}), 16'({1'b1, !adc_frame_clock}));
                if (m == 0) chk(16'({pin_oe[0], pin_out[0]}), 16'({1'b1, adc_frame_clock_core}));
            end
        end
        btn_drive <= 6'h00;
        wr(ADDR_PIN_FN, 16'h8000);
        foreach (codes[k])
        begin
            for (int j = 3; j < 6; j++) wr(ra[j], {2{4'h0, codes[k]}});
            @(posedge clock);
            clock_out_src  <= 1'($urandom);
            temperature_ok <= 1'($urandom);
            fll_locked     <= 1'($urandom);
            cyc(3);
            chk(16'(pin_oe), 16'h003f);
            chk(16'(pin_out), 16'({6{exp_lvl(codes[k])}}));
        end
        for (int j = 3; j < 6; j++) wr(ra[j], 16'h1313);
        cyc(2);
        chk(16'({pin_oe, pin_pull_down_enable}), 16'h003f);
        for (int j = 3; j < 6; j++) wr(ra[j], 16'h0303);
        wr(ADDR_CLK_SRC, 16'h8000);
        wr(ADDR_PIN_FN, 16'ha000);
        cyc(2);
        chk(16'({pin_oe, master_clock}), 16'(master_clock_pin));
        wr(ADDR_CLK_SRC, 16'h0000);
        wr(ADDR_PIN_FN, 16'h8000);
        wr(ADDR_PIN12, 16'h0040);
        wr(ADDR_PIN34, 16'h1010);
        wr(ADDR_PIN56, 16'h1010);
        wr(ADDR_IRQ_MASK, 16'h00c1);
        btn_drive <= 6'h01;
        btn_level <= 6'h00;
        cyc(8);
        wr(ADDR_STATUS, 16'h00ff);
        pin1_event();
        rd(ADDR_STATUS, 16'h0001);
        btn_level[0] <= 1'b0;
        cyc(6);
        rd(ADDR_STATUS, 16'h0001);
        wr(ADDR_STATUS, 16'h0001);
        rd(ADDR_STATUS, 16'h0000);
        cyc(2);
        chk(16'(codec_irq), 16'h0000);
        wr(ADDR_IRQ_MASK, 16'h0040);
        @(posedge clock);
        btn_level[0] <= 1'b1;
        cyc(8);
        chk(16'(codec_irq), 16'h0000);
        rd(ADDR_STATUS, 16'h0001);
        wr(ADDR_INPUT_CTRL, 16'h1001);
        wr(ADDR_STATUS, 16'h00ff);
        btn_level[0] <= 1'b0;
        cyc(8);
        rd(ADDR_STATUS, 16'h0001);
        wr(ADDR_PIN12, 16'h00c0);
        wr(ADDR_INPUT_CTRL, 16'h1000);
        cyc(40);
        wr(ADDR_STATUS, 16'h00ff);
        btn_level[0] <= 1'b1;
        repeat (2) @(posedge clock);
        btn_level[0] <= 1'b0;
        cyc(30);
        rd(ADDR_STATUS, 16'h0000);
        btn_level[0] <= 1'b1;
        cyc(40);
        rd(ADDR_STATUS, 16'h0001);
        wr(ADDR_INPUT_CTRL, 16'h1100);
        wr(ADDR_STATUS, 16'h00ff);
        detect_input_seven <= 1'b1;
        cyc(8);
        rd(ADDR_STATUS, 16'h0040);
        chk(16'(codec_irq), 16'h0001);
        summarize();
    end
endmodule : tb
